// ---- pkg/efa_pkg.sv ----
// Constants and types for the nonvolatile memory access controller.
// Contract
// - Reset during self-timed erase or program sets the write error flag.
// - Unlock port reads as zero and only serves the start sequence.
// - Memory select one targets program Flash, zero targets data EEPROM.
// - Configuration select one targets configuration space, overriding memory select.
// - Write start is ignored while write enable is clear.
// - Clearing write enable does not stop a running cycle.
// - Aborting reset clears the EEPROM address and data registers.
// - Read and write start are set by software, cleared only by hardware.
// - Read start cannot be set while memory select is one.
// - Write completion sets the done flag; only software clears it.
// - Row erase bit makes write start erase a row, cleared on completion.
// - On write error, memory select and row erase keep their values.
// - EEPROM read finishes in one cycle, data register holds the byte.
// - Eight-bit address reaches 256 EEPROM bytes, eight-bit data register.
// - EEPROM byte write erases the location first, then programs, self-timed.
// - Write start launches EEPROM write, Flash row erase or Flash write.
// - EEPROM array is reachable only through the special function registers.
// - Start needs 55h then 0AAh to unlock port, then write start.
// - Write enable and write start set together never start a cycle.
// - Processor stalls during a program Flash write or erase.
// - Control, address and data registers are protected while writing; the code still lets the write enable bit change.
package efa_pkg;

  // ************************************************************
  // Register selectors on the special function register port.
  // ************************************************************
  localparam logic [3:0] SEL_NVM_CONTROL = 4'h0;
  localparam logic [3:0] SEL_UNLOCK_PORT = 4'h1;
  localparam logic [3:0] SEL_EE_ADDRESS = 4'h2;
  localparam logic [3:0] SEL_EE_DATA = 4'h3;
  localparam logic [3:0] SEL_TP_UPPER = 4'h4;
  localparam logic [3:0] SEL_TP_HIGH = 4'h5;
  localparam logic [3:0] SEL_TP_LOW = 4'h6;
  localparam logic [3:0] SEL_TABLE_LATCH = 4'h7;
  localparam logic [3:0] SEL_INT_FLAGS_2 = 4'h8;
  localparam logic [3:0] SEL_INT_ENABLES_2 = 4'h9;
  localparam logic [3:0] SEL_INT_PRIORITY_2 = 4'hA;

  // ************************************************************
  // Control register fields and other bit positions.
  // ************************************************************
  localparam int CTL_READ_START = 0;
  localparam int CTL_WRITE_START = 1;
  localparam int CTL_WRITE_ENABLE = 2;
  localparam int CTL_WRITE_ERROR = 3;
  localparam int CTL_ROW_ERASE = 4;
  localparam int CTL_CONFIG_SELECT = 6;
  localparam int CTL_MEMORY_SELECT = 7;
  localparam int NVM_DONE_BIT = 4;
  localparam int TP_UPPER_WIDTH = 6;

  // ************************************************************
  // Unlock codes and reset values.
  // ************************************************************
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic DONE_PRIORITY_RESET = 1'b1;

  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int unsigned CLK_FREQ_KHZ = 10_000;
  localparam int unsigned FLASH_WRITE_TIME_US = 2_000;
  localparam int unsigned EE_WRITE_TIME_US = 4_000;
  localparam int unsigned FLASH_WRITE_CYCLES = (FLASH_WRITE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int unsigned EE_WRITE_CYCLES = (EE_WRITE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

  typedef enum logic [1:0] {
    UL_IDLE,
    UL_GOT_FIRST,
    UL_ARMED
  } efa_unlock_t;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_EE_WRITE,
    OP_FL_ERASE,
    OP_FL_WRITE,
    OP_CFG_WRITE
  } efa_op_t;

endpackage : efa_pkg

// ---- rtl/efa_ee_array.sv ----
// Data EEPROM cell array held in flip-flops with erase-before-program.
`timescale 1ns/100ps
`default_nettype none
module efa_ee_array #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic eraseStb,
  input wire logic progStb,
  input wire logic [$clog2(DEPTH)-1:0] cellAddr,
  input wire logic [WIDTH-1:0] progData,
  output logic [WIDTH-1:0] readData
);

  logic [WIDTH-1:0] cells [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("Array depth or width out of range.");
  end

  // ************************************************************
  // Cells keep their contents through every reset, as the array is nonvolatile.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (eraseStb) begin
      cells[cellAddr] <= '1;
    end else if (progStb) begin
      cells[cellAddr] <= progData;
    end
  end

  assign readData = cells[cellAddr];

endmodule : efa_ee_array
`default_nettype wire

// ---- rtl/efa_nvm_control.sv ----
// Control registers, unlock sequence and self-timed write engine.
`timescale 1ns/100ps
`default_nettype none
module efa_nvm_control
  import efa_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = FLASH_WRITE_CYCLES,
  parameter int unsigned EE_CYCLES = EE_WRITE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic extMasterResetReq,
  input wire logic watchdogResetReq,
  input wire logic [3:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  output logic [21:0] tablePointer,
  output logic [7:0] tableLatch,
  output logic cpuStall,
  output logic flashRowEraseBusy,
  output logic flashProgramBusy,
  output logic configWriteBusy,
  output logic nvmDoneIrq,
  output logic nvmDonePriority
);

  if (FLASH_CYCLES < 1 || EE_CYCLES < 1) begin : g_check
    $error("Write cycle counts must be at least one.");
  end

  // ************************************************************
  // State.
  // ************************************************************
  logic ctlMemSel_ff;
  logic ctlCfgSel_ff;
  logic ctlRowErase_ff;
  logic ctlWrErr_ff;
  logic ctlWrEn_ff;
  logic ctlWrStart_ff;
  logic ctlRdStart_ff;
  logic [7:0] eeAddr_ff;
  logic [7:0] eeprom_data_reg_ff;
  logic [TP_UPPER_WIDTH-1:0] tpUpper_ff;
  logic [7:0] tpHigh_ff;
  logic [7:0] tpLow_ff;
  logic [7:0] tabLatch_ff;
  logic doneFlag_ff;
  logic doneIe_ff;
  logic donePri_ff;
  logic nvmDoneIrq_ff;
  logic [7:0] sfrRdData_ff;
  logic cpuStall_ff;
  logic flErase_ff;
  logic flProg_ff;
  logic cfgProg_ff;
  logic [31:0] timer_ff;
  efa_unlock_t unlock_ff;
  efa_op_t op_ff;
  efa_op_t nxt_op;
  logic [7:0] arrayRead;

  // ************************************************************
  // Decode.
  // ************************************************************
  function automatic logic hit(input logic [3:0] sel);
    hit = sfrWrEn && (sfrAddr == sel);
  endfunction : hit

  logic busy;
  logic softRst;
  logic abort;
  logic opDone;
  logic startOk;
  logic wrCtl;

  assign busy = (op_ff != OP_IDLE);
  assign softRst = extMasterResetReq || watchdogResetReq;
  assign abort = busy && softRst;
  assign opDone = busy && (timer_ff == 32'h0000_0000);
  assign wrCtl = hit(SEL_NVM_CONTROL);
  // Write enable is taken from the stored bit, so one write setting both cannot start.
  assign startOk = wrCtl && sfrWrData[CTL_WRITE_START] && ctlWrEn_ff &&
                   (unlock_ff == UL_ARMED) && !busy && !softRst;

  // The target is taken from the same control write that sets write start.
  always_comb begin
    if (sfrWrData[CTL_CONFIG_SELECT]) begin
      nxt_op = OP_CFG_WRITE;
    end else if (!sfrWrData[CTL_MEMORY_SELECT]) begin
      nxt_op = OP_EE_WRITE;
    end else if (sfrWrData[CTL_ROW_ERASE]) begin
      nxt_op = OP_FL_ERASE;
    end else begin
      nxt_op = OP_FL_WRITE;
    end
  end

  // ************************************************************
  // Unlock sequence.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (srst || softRst) begin
      unlock_ff <= UL_IDLE;
    end else if (sfrWrEn) begin
      if (sfrAddr != SEL_UNLOCK_PORT) begin
        unlock_ff <= UL_IDLE;
      end else if (sfrWrData == UNLOCK_FIRST) begin
        unlock_ff <= UL_GOT_FIRST;
      end else if (sfrWrData == UNLOCK_SECOND && unlock_ff == UL_GOT_FIRST) begin
        unlock_ff <= UL_ARMED;
      end else begin
        unlock_ff <= UL_IDLE;
      end
    end
  end

  // ************************************************************
  // Self-timed operation engine.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (srst || softRst) begin
      op_ff <= OP_IDLE;
      timer_ff <= 32'h0000_0000;
      cpuStall_ff <= 1'b0;
      flErase_ff <= 1'b0;
      flProg_ff <= 1'b0;
      cfgProg_ff <= 1'b0;
    end else if (startOk) begin
      op_ff <= nxt_op;
      timer_ff <= (nxt_op == OP_EE_WRITE) ? 32'(EE_CYCLES - 1) : 32'(FLASH_CYCLES - 1);
      cpuStall_ff <= (nxt_op != OP_EE_WRITE);
      flErase_ff <= (nxt_op == OP_FL_ERASE);
      flProg_ff <= (nxt_op == OP_FL_WRITE);
      cfgProg_ff <= (nxt_op == OP_CFG_WRITE);
    end else if (opDone) begin
      op_ff <= OP_IDLE;
      cpuStall_ff <= 1'b0;
      flErase_ff <= 1'b0;
      flProg_ff <= 1'b0;
      cfgProg_ff <= 1'b0;
    end else if (busy) begin
      timer_ff <= timer_ff - 32'h0000_0001;
    end
  end

  // ************************************************************
  // Control register.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctlMemSel_ff <= 1'b0;
      ctlCfgSel_ff <= 1'b0;
      ctlRowErase_ff <= 1'b0;
      ctlWrErr_ff <= 1'b0;
      ctlWrEn_ff <= 1'b0;
      ctlWrStart_ff <= 1'b0;
      ctlRdStart_ff <= 1'b0;
    end else if (softRst) begin
      ctlWrEn_ff <= 1'b0;
      ctlWrStart_ff <= 1'b0;
      ctlRdStart_ff <= 1'b0;
      if (abort) begin
        ctlWrErr_ff <= 1'b1;
      end else begin
        ctlRowErase_ff <= 1'b0;
      end
    end else begin
      if (ctlRdStart_ff) begin
        ctlRdStart_ff <= 1'b0;
      end
      if (opDone) begin
        ctlWrStart_ff <= 1'b0;
        ctlWrErr_ff <= 1'b0;
        if (op_ff == OP_FL_ERASE) begin
          ctlRowErase_ff <= 1'b0;
        end
      end
      if (wrCtl && busy) begin
        ctlWrEn_ff <= sfrWrData[CTL_WRITE_ENABLE];
      end else if (wrCtl) begin
        ctlMemSel_ff <= sfrWrData[CTL_MEMORY_SELECT];
        ctlCfgSel_ff <= sfrWrData[CTL_CONFIG_SELECT];
        ctlRowErase_ff <= sfrWrData[CTL_ROW_ERASE];
        ctlWrErr_ff <= sfrWrData[CTL_WRITE_ERROR];
        ctlWrEn_ff <= sfrWrData[CTL_WRITE_ENABLE];
        if (startOk) begin
          ctlWrStart_ff <= 1'b1;
        end
        if (sfrWrData[CTL_READ_START] && !sfrWrData[CTL_MEMORY_SELECT] && !sfrWrData[CTL_CONFIG_SELECT]) begin
          ctlRdStart_ff <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // EEPROM address and data registers.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (srst || softRst) begin
      eeAddr_ff <= BYTE_RESET;
    end else if (hit(SEL_EE_ADDRESS) && !busy) begin
      eeAddr_ff <= sfrWrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || softRst) begin
      eeprom_data_reg_ff <= BYTE_RESET;
    end else if (ctlRdStart_ff) begin
      eeprom_data_reg_ff <= arrayRead;
    end else if (hit(SEL_EE_DATA) && !busy) begin
      eeprom_data_reg_ff <= sfrWrData;
    end
  end

  // The array is wired only to these registers and has no direct access path.
  efa_ee_array #(
    .DEPTH(256),
    .WIDTH(8)
  ) u_array (
    .mclk(mclk),
    .eraseStb(startOk && nxt_op == OP_EE_WRITE),
    .progStb(opDone && op_ff == OP_EE_WRITE),
    .cellAddr(eeAddr_ff),
    .progData(eeprom_data_reg_ff),
    .readData(arrayRead)
  );

  // ************************************************************
  // Table pointer and latch.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (srst || softRst) begin
      tpUpper_ff <= '0;
      tpHigh_ff <= BYTE_RESET;
      tpLow_ff <= BYTE_RESET;
      tabLatch_ff <= BYTE_RESET;
    end else begin
      if (hit(SEL_TP_UPPER)) begin
        tpUpper_ff <= sfrWrData[TP_UPPER_WIDTH-1:0];
      end
      if (hit(SEL_TP_HIGH)) begin
        tpHigh_ff <= sfrWrData;
      end
      if (hit(SEL_TP_LOW)) begin
        tpLow_ff <= sfrWrData;
      end
      if (hit(SEL_TABLE_LATCH)) begin
        tabLatch_ff <= sfrWrData;
      end
    end
  end

  // ************************************************************
  // Completion flag, enable and priority.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (srst || softRst) begin
      doneFlag_ff <= 1'b0;
      doneIe_ff <= 1'b0;
      donePri_ff <= DONE_PRIORITY_RESET;
      nvmDoneIrq_ff <= 1'b0;
    end else begin
      // A completion in the same cycle as a software clear keeps the flag set.
      if (opDone) begin
        doneFlag_ff <= 1'b1;
      end else if (hit(SEL_INT_FLAGS_2)) begin
        doneFlag_ff <= sfrWrData[NVM_DONE_BIT];
      end
      if (hit(SEL_INT_ENABLES_2)) begin
        doneIe_ff <= sfrWrData[NVM_DONE_BIT];
      end
      if (hit(SEL_INT_PRIORITY_2)) begin
        donePri_ff <= sfrWrData[NVM_DONE_BIT];
      end
      nvmDoneIrq_ff <= doneFlag_ff && doneIe_ff;
    end
  end

  // ************************************************************
  // Read port.
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      sfrRdData_ff <= BYTE_RESET;
    end else if (sfrRdEn) begin
      case (sfrAddr)
        SEL_NVM_CONTROL: begin
          sfrRdData_ff <= {ctlMemSel_ff, ctlCfgSel_ff, 1'b0, ctlRowErase_ff,
                           ctlWrErr_ff, ctlWrEn_ff, ctlWrStart_ff, ctlRdStart_ff};
        end
        SEL_UNLOCK_PORT: begin
          sfrRdData_ff <= BYTE_RESET;
        end
        SEL_EE_ADDRESS: begin
          sfrRdData_ff <= eeAddr_ff;
        end
        SEL_EE_DATA: begin
          sfrRdData_ff <= eeprom_data_reg_ff;
        end
        SEL_TP_UPPER: begin
          sfrRdData_ff <= {2'b00, tpUpper_ff};
        end
        SEL_TP_HIGH: begin
          sfrRdData_ff <= tpHigh_ff;
        end
        SEL_TP_LOW: begin
          sfrRdData_ff <= tpLow_ff;
        end
        SEL_TABLE_LATCH: begin
          sfrRdData_ff <= tabLatch_ff;
        end
        SEL_INT_FLAGS_2: begin
          sfrRdData_ff <= 8'(doneFlag_ff) << NVM_DONE_BIT;
        end
        SEL_INT_ENABLES_2: begin
          sfrRdData_ff <= 8'(doneIe_ff) << NVM_DONE_BIT;
        end
        SEL_INT_PRIORITY_2: begin
          sfrRdData_ff <= 8'(donePri_ff) << NVM_DONE_BIT;
        end
        default: begin
          sfrRdData_ff <= BYTE_RESET;
        end
      endcase
    end
  end

  assign sfrRdData = sfrRdData_ff;
  assign tablePointer = {tpUpper_ff, tpHigh_ff, tpLow_ff};
  assign tableLatch = tabLatch_ff;
  assign cpuStall = cpuStall_ff;
  assign flashRowEraseBusy = flErase_ff;
  assign flashProgramBusy = flProg_ff;
  assign configWriteBusy = cfgProg_ff;
  assign nvmDoneIrq = nvmDoneIrq_ff;
  assign nvmDonePriority = donePri_ff;

endmodule : efa_nvm_control
`default_nettype wire

// ---- bench/efa_nvm_control_sva.sv ----
// Checker for the register port and busy outputs of the nonvolatile access controller.
`timescale 1ns/100ps
`default_nettype none
module efa_nvm_control_sva
  import efa_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = 4,
  parameter int unsigned EE_CYCLES = 6
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic extMasterResetReq,
  input wire logic watchdogResetReq,
  input wire logic [3:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic [21:0] tablePointer,
  input wire logic [7:0] tableLatch,
  input wire logic cpuStall,
  input wire logic flashRowEraseBusy,
  input wire logic flashProgramBusy,
  input wire logic configWriteBusy,
  input wire logic nvmDoneIrq,
  input wire logic nvmDonePriority
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic abort;
  logic ctlRead;
  logic [15:0] stallCnt_ff;
  assign abort = extMasterResetReq || watchdogResetReq;
  assign ctlRead = sfrRdEn && (sfrAddr == SEL_NVM_CONTROL);
  // Counts the stall cycles so far, so long timer values never need unrolled repetition.
  always_ff @(posedge mclk) begin
    if (srst || !cpuStall) begin
      stallCnt_ff <= 16'h0000;
    end else begin
      stallCnt_ff <= stallCnt_ff + 16'h0001;
    end
  end
  a_stall_full_length: assert property ($fell(cpuStall) && !$past(abort) && !$past(srst) |-> stallCnt_ff == 16'(FLASH_CYCLES))
    else $error("stall did not last the programming time");
  a_stall_bounded: assert property (cpuStall |-> stallCnt_ff < 16'(FLASH_CYCLES))
    else $error("stall ran past the programming time");
  a_stall_matches_busy: assert property (cpuStall == (flashRowEraseBusy || flashProgramBusy || configWriteBusy))
    else $error("stall does not match the busy outputs");
  a_abort_ends_op: assert property (abort |=> !cpuStall)
    else $error("operation kept running after an aborting reset");
  a_unlock_reads_zero: assert property (sfrRdEn && sfrAddr == SEL_UNLOCK_PORT |=> sfrRdData == 8'h00)
    else $error("unlock port read not zero");
  a_unmapped_zero: assert property (sfrRdEn && sfrAddr > SEL_INT_PRIORITY_2 |=> sfrRdData == 8'h00)
    else $error("unmapped selector read not zero");
  a_read_data_held: assert property (!$past(sfrRdEn) && !$past(srst) |-> $stable(sfrRdData))
    else $error("read data changed without a read");
  a_erase_ctl_bits: assert property (flashRowEraseBusy && ctlRead |=> sfrRdData[7:6] == 2'b10 && sfrRdData[4] && sfrRdData[1])
    else $error("control bits wrong during row erase");
  a_program_ctl_bits: assert property (flashProgramBusy && ctlRead |=> sfrRdData[7:6] == 2'b10 && !sfrRdData[4] && sfrRdData[1])
    else $error("control bits wrong during flash write");
  a_config_ctl_bits: assert property (configWriteBusy && ctlRead |=> sfrRdData[6] && sfrRdData[1])
    else $error("control bits wrong during configuration write");
  c_stall_done: cover property ($fell(cpuStall));
  c_abort_busy: cover property (abort && cpuStall);
  c_unlock_read: cover property (sfrRdEn && sfrAddr == SEL_UNLOCK_PORT);
endmodule : efa_nvm_control_sva
bind efa_nvm_control efa_nvm_control_sva #(.FLASH_CYCLES(FLASH_CYCLES), .EE_CYCLES(EE_CYCLES)) u_sva (
  .mclk(mclk), .srst(srst), .extMasterResetReq(extMasterResetReq), .watchdogResetReq(watchdogResetReq),
  .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
  .tablePointer(tablePointer), .tableLatch(tableLatch), .cpuStall(cpuStall),
  .flashRowEraseBusy(flashRowEraseBusy), .flashProgramBusy(flashProgramBusy),
  .configWriteBusy(configWriteBusy), .nvmDoneIrq(nvmDoneIrq), .nvmDonePriority(nvmDonePriority));
`default_nettype wire

// ---- bench/efa_nvm_control_tb_top.sv ----
// Self-checking bench for the nonvolatile access controller.
`timescale 1ns/100ps
`default_nettype none
module efa_nvm_control_tb_top
  import efa_pkg::*;
;
  localparam int FL = 4;
  localparam int EE = 20;
  localparam time DLY = 10ns;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic extMasterResetReq = 1'b0;
  logic watchdogResetReq = 1'b0;
  logic [3:0] sfrAddr = 4'h0;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrRdEn = 1'b0;
  logic [7:0] sfrRdData;
  logic [21:0] tablePointer;
  logic [7:0] tableLatch;
  logic cpuStall, flashRowEraseBusy, flashProgramBusy, configWriteBusy, nvmDoneIrq, nvmDonePriority;
  int err_count = 0;
  int tests_run = 0;
  int stallLen = 0;
  logic [2:0] busySeen = 3'b000;
  logic rdSeen = 1'b0;
  logic [15:0] expQ[$];
  logic [7:0] vals[16];
  logic [7:0] d;
  logic [31:0] bad[4] = '{32'h0055_AA02, 32'h0055_AA06, 32'h04AA_5506, 32'h0455_5406};
  logic [7:0] fops[3] = '{8'h94, 8'h84, 8'hC4};
  always #50 mclk = ~mclk;
  efa_nvm_control #(.FLASH_CYCLES(FL), .EE_CYCLES(EE)) DUT (.mclk(mclk), .srst(srst),
    .extMasterResetReq(extMasterResetReq), .watchdogResetReq(watchdogResetReq), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .tablePointer(tablePointer), .tableLatch(tableLatch), .cpuStall(cpuStall),
    .flashRowEraseBusy(flashRowEraseBusy), .flashProgramBusy(flashProgramBusy),
    .configWriteBusy(configWriteBusy), .nvmDoneIrq(nvmDoneIrq), .nvmDonePriority(nvmDonePriority));
  // ************************************************************
  // Checking and closing.
  // ************************************************************
  task automatic cmp_rd(input logic [7:0] exp, input logic [7:0] mask, input logic [7:0] got);
    tests_run++;
    if ((got & mask) !== (exp & mask)) begin
      err_count++;
      $display("[FAIL] %0t read got %h expected %h mask %h", $time, got, exp, mask);
    end
  endtask : cmp_rd
  task automatic cmp_pin(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_pin
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // Read data lands one edge after the strobe, so the oldest note is matched on the edge after that.
  always @(posedge mclk) begin
    if (rdSeen) begin
      cmp_rd(expQ[0][15:8], expQ[0][7:0], sfrRdData);
      void'(expQ.pop_front());
    end
    rdSeen <= sfrRdEn;
    if (cpuStall === 1'b1) begin
      stallLen <= stallLen + 1;
    end
    busySeen <= busySeen | {configWriteBusy, flashProgramBusy, flashRowEraseBusy};
  end
  // ************************************************************
  // Bus cycles; each starts just after an edge and leaves an idle edge behind it.
  // ************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    sfrAddr = a;
    sfrWrData = v;
    sfrWrEn = 1'b1;
    @(posedge mclk);
    #DLY sfrWrEn = 1'b0;
    @(posedge mclk);
    #DLY;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
    expQ.push_back({exp, mask});
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(posedge mclk);
    #DLY sfrRdEn = 1'b0;
    @(posedge mclk);
    #DLY;
  endtask : rd
  task automatic seq(input logic [7:0] c1, input logic [7:0] u1, input logic [7:0] u2, input logic [7:0] c2);
    wr(SEL_NVM_CONTROL, c1);
    wr(SEL_UNLOCK_PORT, u1);
    wr(SEL_UNLOCK_PORT, u2);
    wr(SEL_NVM_CONTROL, c2);
  endtask : seq
  task automatic ee_read(input logic [7:0] a, input logic [7:0] exp);
    wr(SEL_EE_ADDRESS, a);
    wr(SEL_NVM_CONTROL, 8'h01);
    rd(SEL_NVM_CONTROL, 8'h00, 8'h01);
    rd(SEL_EE_DATA, exp, 8'hFF);
  endtask : ee_read
  task automatic ee_write(input logic [7:0] a, input logic [7:0] v);
    wr(SEL_INT_ENABLES_2, 8'h10);
    wr(SEL_EE_ADDRESS, a);
    wr(SEL_EE_DATA, v);
    // The start write also sets the error bit, so only a normal completion can clear it.
    seq(8'h04, UNLOCK_FIRST, UNLOCK_SECOND, 8'h0E);
    rd(SEL_NVM_CONTROL, 8'h0E, 8'hFF);
    wr(SEL_NVM_CONTROL, 8'h00);
    wr(SEL_EE_ADDRESS, ~a);
    rd(SEL_NVM_CONTROL, 8'h0A, 8'hFF);
    repeat (EE) @(posedge mclk);
    #DLY;
    rd(SEL_NVM_CONTROL, 8'h00, 8'hFF);
    rd(SEL_INT_FLAGS_2, 8'h10, 8'hFF);
    cmp_pin("done irq", 16'h0001, {15'h0000, nvmDoneIrq});
    rd(SEL_EE_ADDRESS, a, 8'hFF);
    ee_read(a, v);
    wr(SEL_INT_FLAGS_2, 8'h00);
    rd(SEL_INT_FLAGS_2, 8'h00, 8'hFF);
  endtask : ee_write
  // ************************************************************
  // Scenarios.
  // ************************************************************
  initial begin
    void'($urandom(32'h56cc_1258));
    repeat (12) @(posedge mclk);
    #DLY srst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], (i == 10) ? 8'h10 : 8'h00, 8'hFF);
    end
    for (int i = 2; i < 10; i++) begin
      vals[i] = 8'($urandom);
      wr(i[3:0], vals[i]);
      rd(i[3:0], vals[i], (i == 4) ? 8'h3F : ((i > 7) ? 8'h10 : 8'hFF));
    end
    cmp_pin("table pointer", {vals[5], vals[6]}, tablePointer[15:0]);
    cmp_pin("priority", 16'h0001, {15'h0000, nvmDonePriority});
    cmp_pin("table latch", {8'h00, tableLatch}, {8'h00, vals[7]});
    wr(SEL_UNLOCK_PORT, 8'hFF);
    rd(SEL_UNLOCK_PORT, 8'h00, 8'hFF);
    wr(SEL_INT_FLAGS_2, 8'h00);
    ee_write(8'h00, 8'($urandom));
    d = 8'($urandom);
    ee_write(8'hFF, d);
    wr(SEL_EE_DATA, ~d);
    foreach (bad[k]) begin
      seq(bad[k][31:24], bad[k][23:16], bad[k][15:8], bad[k][7:0]);
      rd(SEL_NVM_CONTROL, 8'h00, 8'h02);
    end
    ee_read(8'hFF, d);
    wr(SEL_NVM_CONTROL, 8'h81);
    rd(SEL_NVM_CONTROL, 8'h80, 8'hFF);
    rd(SEL_EE_DATA, d, 8'hFF);
    foreach (fops[k]) begin
      stallLen = 0;
      busySeen = 3'b000;
      seq(fops[k], UNLOCK_FIRST, UNLOCK_SECOND, fops[k] | 8'h02);
      rd(SEL_NVM_CONTROL, fops[k] | 8'h02, 8'hFF);
      repeat (FL + 4) @(posedge mclk);
      #DLY;
      cmp_pin("stall length", 16'(FL), 16'(stallLen));
      cmp_pin("busy kind", 16'(1 << k), {13'h0000, busySeen});
      rd(SEL_NVM_CONTROL, fops[k] & 8'hEF, 8'hFF);
      rd(SEL_INT_FLAGS_2, 8'h10, 8'h10);
      wr(SEL_INT_FLAGS_2, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      seq((k == 0) ? 8'h94 : 8'h04, UNLOCK_FIRST, UNLOCK_SECOND, (k == 0) ? 8'h96 : 8'h06);
      extMasterResetReq = (k == 0);
      watchdogResetReq = (k == 1);
      @(posedge mclk);
      #DLY extMasterResetReq = 1'b0;
      watchdogResetReq = 1'b0;
      rd(SEL_NVM_CONTROL, (k == 0) ? 8'h98 : 8'h08, 8'hFF);
      rd(SEL_EE_ADDRESS, 8'h00, 8'hFF);
      rd(SEL_EE_DATA, 8'h00, 8'hFF);
    end
    ee_write(8'($urandom), 8'($urandom));
    repeat (4) @(posedge mclk);
    close_out();
  end
  // A hang is cut off well beyond the few hundred cycles the scenarios need.
  initial begin
    #(5_000_000);
    err_count++;
    close_out();
  end
endmodule : efa_nvm_control_tb_top
`default_nettype wire
